// ==== hdl/hstc_pkg.sv ====
package hstc_pkg;

  // Register byte offsets (each register takes one aligned APB word)
  localparam logic [7:0] HSTC_OFS_GAIN = 8'h00;
  localparam logic [7:0] HSTC_OFS_LOOP = 8'h04;
  localparam logic [7:0] HSTC_OFS_SOFS = 8'h08;
  localparam logic [7:0] HSTC_OFS_PCOF = 8'h0C;
  localparam logic [7:0] HSTC_OFS_HCBT = 8'h10;
  localparam logic [7:0] HSTC_OFS_DIAG = 8'h38;
  localparam logic [7:0] HSTC_OFS_STAT = 8'h40;

  // Printed register indexes (byte address is four times these)
  localparam logic [5:0] HSTC_IDX_GAIN = 6'h00;
  localparam logic [5:0] HSTC_IDX_LOOP = 6'h01;
  localparam logic [5:0] HSTC_IDX_SOFS = 6'h02;
  localparam logic [5:0] HSTC_IDX_PCOF = 6'h03;
  localparam logic [5:0] HSTC_IDX_HCBT = 6'h04;
  localparam logic [5:0] HSTC_IDX_DIAG = 6'h0E;

  // Writable bit masks per register
  localparam logic [7:0] HSTC_MSK_GAIN = 8'hFF;
  localparam logic [7:0] HSTC_MSK_LOOP = 8'hFF;
  localparam logic [7:0] HSTC_MSK_SOFS = 8'h7F;
  localparam logic [7:0] HSTC_MSK_PCOF = 8'hFF;
  localparam logic [7:0] HSTC_MSK_HCBT = 8'h8F;
  localparam logic [7:0] HSTC_MSK_DIAG = 8'hFF;

  // Reset values
  localparam logic [7:0] HSTC_RST_GAIN = 8'h00;
  localparam logic [7:0] HSTC_RST_LOOP = 8'h00;
  localparam logic [7:0] HSTC_RST_SOFS = 8'h00;
  localparam logic [7:0] HSTC_RST_PCOF = 8'h00;
  localparam logic [7:0] HSTC_RST_HCBT = 8'h08;
  localparam logic [7:0] HSTC_RST_DIAG = 8'h00;

  // Field positions
  localparam int HSTC_POS_CGAIN = 6;
  localparam int HSTC_POS_FLAG = 7;
  localparam int HSTC_POS_SIGN = 6;

  // Diagnostic mode codes
  localparam logic [7:0] HSTC_DM_NORMAL = 8'h00;
  localparam logic [7:0] HSTC_DM_SIN = 8'h20;
  localparam logic [7:0] HSTC_DM_COS = 8'h21;
  localparam logic [7:0] HSTC_DM_OUT = 8'h22;
  localparam logic [7:0] HSTC_DM_REF = 8'h43;
  localparam logic [7:0] HSTC_DM_CLK = 8'hC0;

  // Pin route selects
  typedef enum logic [2:0] {
    HSTC_RT_NORMAL = 3'h0,
    HSTC_RT_SIN = 3'h1,
    HSTC_RT_COS = 3'h3,
    HSTC_RT_OUT = 3'h2,
    HSTC_RT_REF = 3'h6,
    HSTC_RT_CLK = 3'h7,
    HSTC_RT_OTHER = 3'h5
  } hstc_route_t;

  // Amplitude loop states, Gray along idle, ramp, track
  typedef enum logic [1:0] {
    HSTC_AL_IDLE = 2'b00,
    HSTC_AL_RAMP = 2'b01,
    HSTC_AL_TRACK = 2'b11,
    HSTC_AL_LIMIT = 2'b10
  } hstc_loop_t;

  // Loop gain step period
  localparam int HSTC_CLK_HZ = 40000000;
  localparam int HSTC_STEP_US = 10;
  localparam int HSTC_STEP_CYC = HSTC_CLK_HZ / 1000000 * HSTC_STEP_US;

endpackage

// ==== hdl/hstc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; change counts once stages two and three agree
module hstc_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous level in, filtered level out
  input wire logic async_in,
  output logic sync_out
);

  // Stage registers and filtered level
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } hstc_sync_t;

  hstc_sync_t st_q;
  hstc_sync_t st_d;

  // Next state: first stage feeds only the second
  always_comb begin
    st_d = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.lvl;

endmodule // hstc_sync
`default_nettype wire

// ==== hdl/hstc_top.sv ====
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module hstc_top import hstc_pkg::*; #(
  parameter int STEP_CYC = HSTC_STEP_CYC,
  parameter int FGAIN_W = 6
) (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Programming pin tied to digital supply (asynchronous)
  input wire logic prog_voltage_pin,
  // Amplitude comparison from the analog loop (asynchronous)
  input wire logic amp_below_setpoint,
  input wire logic amp_above_setpoint,
  // Normal digital outputs and internal clock monitor
  input wire logic inc_a,
  input wire logic inc_b,
  input wire logic inc_z,
  input wire logic com_u,
  input wire logic internal_clock_monitor,
  // Analog front end controls
  output logic [1:0] coarse_gain,
  output logic [FGAIN_W-1:0] second_gain,
  output logic [6:0] cos_ratio_trim,
  output logic sin_offset_neg,
  output logic [5:0] sin_offset_mv,
  output logic cos_offset_neg,
  output logic [5:0] cos_offset_mv,
  output logic low_power_select,
  output logic [3:0] bias_trim,
  output logic fast_hall_clock,
  // Pin routing
  output logic [2:0] pin_route,
  output logic diag_active,
  output logic pin_a,
  output logic pin_b,
  output logic pin_z,
  output logic pin_u
);

  // All block state but the synchroniser flops in one record, registered by a single process; the
  // loop, divider and read latch live here too so reset covers them all
  typedef struct packed {
    logic [7:0] gain;
    logic [7:0] loop;
    logic [7:0] sofs;
    logic [7:0] pcof;
    logic [7:0] hcbt;
    logic [7:0] diag;
    hstc_loop_t lst;
    logic [FGAIN_W-1:0] lgain;
    logic [15:0] tick;
    logic [31:0] rdata;
    logic err;
    logic [2:0] route;
    logic dact;
    logic [3:0] pins;
    logic rdy; // Answer cycle of an access
  } hstc_state_t;

  // Registered state and its next value
  hstc_state_t st_q;
  hstc_state_t st_d;

  // Synchronised pin inputs; the analog comparators and the programming pin
  // are not timed to pclk, so each passes four flops (three stages and the filtered level) before use
  logic prog_s;
  logic below_s;
  logic above_s;

  hstc_sync u_sync_prog (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(prog_voltage_pin),
    .sync_out(prog_s)
  );
  hstc_sync u_sync_below (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(amp_below_setpoint),
    .sync_out(below_s)
  );
  hstc_sync u_sync_above (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(amp_above_setpoint),
    .sync_out(above_s)
  );

  // Access phase qualifiers. The slave inserts one wait state so that read
  // data leaves a flop in the cycle where pready is high
  logic acc;
  logic wr;
  assign acc = psel & penable;
  // Writes take effect only at the edge where pready is sampled high
  assign wr = acc & pwrite & st_q.rdy;

  // Next-state logic
  always_comb begin
    // Scratch values, set at the top so nothing is latched
    logic [7:0] w8;
    logic step;
    logic mapped;
    w8 = pwdata[7:0];
    step = 1'b0;
    mapped = 1'b1;
    st_d = st_q;

    // Wait state: high only in the second access cycle of a transfer
    st_d.rdy = acc & ~st_q.rdy;

    // Register writes; masks drop unassigned bits so they read back zero.
    // Only the low byte of the word is used; the upper bits are ignored
    if (wr) begin
      case (paddr)
        HSTC_OFS_GAIN: st_d.gain = w8 & HSTC_MSK_GAIN;
        HSTC_OFS_LOOP: st_d.loop = w8 & HSTC_MSK_LOOP;
        HSTC_OFS_SOFS: st_d.sofs = w8 & HSTC_MSK_SOFS;
        HSTC_OFS_PCOF: st_d.pcof = w8 & HSTC_MSK_PCOF;
        HSTC_OFS_HCBT: st_d.hcbt = w8 & HSTC_MSK_HCBT;
        HSTC_OFS_DIAG: st_d.diag = w8 & HSTC_MSK_DIAG;
        // Writes to the status word or to gaps change nothing
        default: ;
      endcase
    end

    // Read mux, latched in the first access cycle; status shows loop state
    // and gain. Latching once keeps prdata steady through the answer cycle
    if (acc && !pwrite && !st_q.rdy) begin
      case (paddr)
        HSTC_OFS_GAIN: st_d.rdata = {24'h000000, st_q.gain};
        HSTC_OFS_LOOP: st_d.rdata = {24'h000000, st_q.loop};
        HSTC_OFS_SOFS: st_d.rdata = {24'h000000, st_q.sofs};
        HSTC_OFS_PCOF: st_d.rdata = {24'h000000, st_q.pcof};
        HSTC_OFS_HCBT: st_d.rdata = {24'h000000, st_q.hcbt};
        HSTC_OFS_DIAG: st_d.rdata = {24'h000000, st_q.diag};
        HSTC_OFS_STAT: st_d.rdata = {21'h000000, st_q.dact, st_q.lst,
                                     2'h0, st_q.lgain};
        // Gaps read as zero
        default: st_d.rdata = 32'h00000000;
      endcase
    end

    // Unmapped addresses answer with an error; pslverr is only shown while
    // pready is high, so this bit may lead the answer by a cycle
    case (paddr)
      HSTC_OFS_GAIN, HSTC_OFS_LOOP, HSTC_OFS_SOFS, HSTC_OFS_PCOF,
      HSTC_OFS_HCBT, HSTC_OFS_DIAG, HSTC_OFS_STAT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    st_d.err = acc & ~mapped;

    // Loop step divider. The step must be slower than the analog settling
    // plus the synchroniser delay, or the loop hunts around the setpoint
    if (st_q.tick >= 16'(STEP_CYC - 1)) begin
      st_d.tick = 16'h0000;
      step = 1'b1;
    end else begin
      st_d.tick = st_q.tick + 16'h0001;
    end

    // Amplitude loop: ramp from unity up, then track both ways. Turning the
    // loop off drops the loop gain to unity so a later enable ramps afresh
    if (!st_q.loop[HSTC_POS_FLAG]) begin
      st_d.lst = HSTC_AL_IDLE;
      st_d.lgain = '0;
    end else if (step) begin
      case (st_q.lst)
        // First step after enable starts the ramp from unity gain
        HSTC_AL_IDLE: st_d.lst = HSTC_AL_RAMP;
        HSTC_AL_RAMP: begin
          // Raise gain until setpoint reached after switch-on; the comparator
          // answer is late, so the ramp may pass the setpoint by a step or two
          if (!below_s) begin
            st_d.lst = HSTC_AL_TRACK;
          end else if (&st_q.lgain) begin
            st_d.lst = HSTC_AL_LIMIT;
          end else begin
            st_d.lgain = st_q.lgain + 1'b1;
          end
        end
        HSTC_AL_TRACK, HSTC_AL_LIMIT: begin
          // Correct in either direction; pinned ends show as limit
          // A pinned end means software must pick another coarse gain
          if (below_s && !(&st_q.lgain)) begin
            st_d.lgain = st_q.lgain + 1'b1;
            st_d.lst = HSTC_AL_TRACK;
          end else if (above_s && (|st_q.lgain)) begin
            st_d.lgain = st_q.lgain - 1'b1;
            st_d.lst = HSTC_AL_TRACK;
          end else if (below_s || above_s) begin
            st_d.lst = HSTC_AL_LIMIT;
          end
        end
        default: st_d.lst = HSTC_AL_IDLE;
      endcase
    end

    // Diagnostics need prog pin and a nonzero code. The route is decoded
    // from the next flag value so flag and route change on the same edge
    st_d.dact = prog_s && (st_q.diag != HSTC_DM_NORMAL);
    if (!st_d.dact) begin
      st_d.route = HSTC_RT_NORMAL;
    end else begin
      case (st_q.diag)
        HSTC_DM_SIN: st_d.route = HSTC_RT_SIN;
        HSTC_DM_COS: st_d.route = HSTC_RT_COS;
        HSTC_DM_OUT: st_d.route = HSTC_RT_OUT;
        HSTC_DM_REF: st_d.route = HSTC_RT_REF;
        HSTC_DM_CLK: st_d.route = HSTC_RT_CLK;
        // Unknown nonzero codes still take the pins off their normal outputs
        default: st_d.route = HSTC_RT_OTHER;
      endcase
    end

    // Pins: normal outputs, clock monitor on pin_a in clock diagnostics, else released for analog taps.
    // The pins follow the registered route, one cycle behind it, so a
    // mode change never shows a mixed set of normal and monitor levels
    if (st_q.route == HSTC_RT_NORMAL) begin
      st_d.pins = {com_u, inc_z, inc_b, inc_a};
    end else if (st_q.route == HSTC_RT_CLK) begin
      st_d.pins = {3'b000, internal_clock_monitor};
    end else begin
      st_d.pins = 4'h0;
    end
  end

  // State register; every field clears, then the trim registers take their
  // reset values (bias trim starts at its nominal midpoint)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.gain <= HSTC_RST_GAIN;
      st_q.loop <= HSTC_RST_LOOP;
      st_q.sofs <= HSTC_RST_SOFS;
      st_q.pcof <= HSTC_RST_PCOF;
      st_q.hcbt <= HSTC_RST_HCBT;
      st_q.diag <= HSTC_RST_DIAG;
      st_q.lst <= HSTC_AL_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // APB answer: one wait state; pready and prdata are flop outputs
  assign pready = st_q.rdy;
  assign prdata = st_q.rdata;
  // Error shown only in the answer cycle
  assign pslverr = st_d.err & st_q.rdy;

  // Front end controls; fine gain yields to loop gain when enabled. The
  // analog side decodes the codes; this block only holds and routes them
  assign coarse_gain = st_q.gain[HSTC_POS_CGAIN +: 2];
  assign second_gain = st_q.loop[HSTC_POS_FLAG] ? st_q.lgain
                                                : st_q.gain[FGAIN_W-1:0];
  // Trims pass through as stored; sign handling is analog
  assign cos_ratio_trim = st_q.loop[6:0];
  assign sin_offset_neg = st_q.sofs[HSTC_POS_SIGN];
  assign sin_offset_mv = st_q.sofs[5:0];
  assign cos_offset_neg = st_q.pcof[HSTC_POS_SIGN];
  assign cos_offset_mv = st_q.pcof[5:0];
  assign low_power_select = st_q.pcof[HSTC_POS_FLAG];
  assign bias_trim = st_q.hcbt[3:0];
  assign fast_hall_clock = st_q.hcbt[HSTC_POS_FLAG];
  // Zero angle convention lives in the analog path; code passes through
  assign pin_route = st_q.route;
  // Route flag and pin levels, all straight from flops
  assign diag_active = st_q.dact;
  assign pin_a = st_q.pins[0];
  assign pin_b = st_q.pins[1];
  assign pin_z = st_q.pins[2];
  assign pin_u = st_q.pins[3];

endmodule // hstc_top
`default_nettype wire

// ==== verif/hstc_afe_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Front end: amplitude follows loop gain against a target
module hstc_afe_model (
  // Clock
  input wire logic pclk,
  // Gain applied and the gain that meets the setpoint
  input wire logic [5:0] second_gain,
  // Above 0x3F the loop gain can never reach it and runs out of range
  input wire logic [6:0] target,
  // Comparator levels
  output logic amp_below_setpoint = 1'b0,
  output logic amp_above_setpoint = 1'b0
);
  // Registered, so the loop sees a late analog answer
  always @(posedge pclk) begin
    amp_below_setpoint <= {1'b0, second_gain} < target;
    amp_above_setpoint <= {1'b0, second_gain} > target;
  end
endmodule // hstc_afe_model
`default_nettype wire

// ==== verif/hstc_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// Port watch of the trim bank; one clock domain
module hstc_monitor import hstc_pkg::*; (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Pins in
  input wire logic prog_voltage_pin,
  input wire logic inc_a,
  input wire logic inc_b,
  input wire logic inc_z,
  input wire logic com_u,
  input wire logic internal_clock_monitor,
  // Trim and route outputs
  input wire logic [1:0] coarse_gain,
  input wire logic [6:0] cos_ratio_trim,
  input wire logic sin_offset_neg,
  input wire logic low_power_select,
  input wire logic [3:0] bias_trim,
  input wire logic fast_hall_clock,
  input wire logic [2:0] pin_route,
  input wire logic diag_active,
  input wire logic pin_a,
  input wire logic pin_b,
  input wire logic pin_z,
  input wire logic pin_u
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Write lands at the edge where pready is sampled high
  logic wr;
  assign wr = psel && penable && pwrite && pready;
  a_coarse_gain: assert property (wr && paddr == HSTC_OFS_GAIN
    |=> coarse_gain == $past(pwdata[7:6])) else $error("coarse gain");
  a_ratio_trim: assert property (wr && paddr == HSTC_OFS_LOOP
    |=> cos_ratio_trim == $past(pwdata[6:0])) else $error("ratio trim");
  a_sine_sign: assert property (wr && paddr == HSTC_OFS_SOFS
    |=> sin_offset_neg == $past(pwdata[6])) else $error("sine sign");
  a_power_mode: assert property (wr && paddr == HSTC_OFS_PCOF
    |=> low_power_select == $past(pwdata[7])) else $error("power mode");
  a_bias_clock: assert property (wr && paddr == HSTC_OFS_HCBT
    |=> {fast_hall_clock, bias_trim} == {$past(pwdata[7]), $past(pwdata[3:0])})
    else $error("bias or clock");
  // Six cycles covers the three-stage filter plus the flag register
  a_diag_gate: assert property (!prog_voltage_pin [*6] |-> !diag_active)
    else $error("diag without pin");
  a_clock_route: assert property (pin_route == HSTC_RT_CLK
    |=> pin_a == $past(internal_clock_monitor)) else $error("clock not on pin");
  a_normal_route: assert property (pin_route == HSTC_RT_NORMAL
    |=> {pin_u, pin_z, pin_b, pin_a} == $past({com_u, inc_z, inc_b, inc_a}))
    else $error("normal not on pins");
endmodule // hstc_monitor

bind hstc_top hstc_monitor i_hstc_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .prog_voltage_pin, .inc_a, .inc_b, .inc_z, .com_u,
  .internal_clock_monitor, .coarse_gain, .cos_ratio_trim, .sin_offset_neg, .low_power_select,
  .bias_trim, .fast_hall_clock, .pin_route, .diag_active, .pin_a, .pin_b, .pin_z, .pin_u);
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Random trims with corner codes, diag routes and loop tracking
module tb_top import hstc_pkg::*;;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, e;
  logic prog_voltage_pin = '0, inc_a = '0, inc_b = '0, inc_z = '0, com_u = '0;
  logic internal_clock_monitor = '0, pready, pslverr, amp_below_setpoint, amp_above_setpoint;
  logic sin_offset_neg, cos_offset_neg, low_power_select, fast_hall_clock, diag_active;
  logic pin_a, pin_b, pin_z, pin_u, lim = '0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [1:0] coarse_gain;
  logic [5:0] second_gain, sin_offset_mv, cos_offset_mv, target = 6'h14;
  logic [6:0] cos_ratio_trim;
  logic [3:0] bias_trim;
  logic [2:0] pin_route;
  logic [7:0] ofs [6] = '{HSTC_OFS_GAIN, HSTC_OFS_LOOP, HSTC_OFS_SOFS, HSTC_OFS_PCOF,
    HSTC_OFS_HCBT, HSTC_OFS_DIAG};
  logic [7:0] msk [6] = '{8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'h8F, 8'hFF};
  logic [7:0] codes [7] = '{8'h00, 8'h20, 8'h21, 8'h22, 8'h43, 8'hC0, 8'h01};
  logic [2:0] routes [7] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7, 3'h5};
  integer seed = 32'hBA54, pseed = 32'hBA54;
  int n_mismatch = 0, tests_run = 0, cycles = 0;
  // Short loop step keeps tracking runs brief
  hstc_top #(.STEP_CYC(4)) i_hstc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .prog_voltage_pin, .amp_below_setpoint,
    .amp_above_setpoint, .inc_a, .inc_b, .inc_z, .com_u, .internal_clock_monitor, .coarse_gain,
    .second_gain, .cos_ratio_trim, .sin_offset_neg, .sin_offset_mv, .cos_offset_neg,
    .cos_offset_mv, .low_power_select, .bias_trim, .fast_hall_clock, .pin_route, .diag_active,
    .pin_a, .pin_b, .pin_z, .pin_u);
  hstc_afe_model i_hstc_afe_model (.pclk, .second_gain, .target({lim, target}),
    .amp_below_setpoint, .amp_above_setpoint);
  // 40 MHz clock
  always #12.5 pclk = ~pclk;
  // Normal outputs toggle at random
  always @(posedge pclk) {inc_a, inc_b, inc_z, com_u, internal_clock_monitor} <= 5'($random(pseed));
  // Hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      $display("unexpected at %0t: timeout", $time);
      finish_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %h not %h", $time, got, exp);
    end
  endtask
  // One transfer: setup, access until pready, data and error taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    er = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Outputs tied to one register, packed like its byte
  function automatic logic [7:0] obs(input int i);
    case (i)
      0: return {coarse_gain, second_gain};
      1: return {1'b0, cos_ratio_trim};
      2: return {1'b0, sin_offset_neg, sin_offset_mv};
      3: return {low_power_select, cos_offset_neg, cos_offset_mv};
      4: return {fast_hall_clock, 3'h0, bias_trim};
      default: return {7'h0, diag_active};
    endcase
  endfunction
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    int i;
    logic [31:0] w;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, ofs[k], 32'h0, e);
      check(rd, k == 4 ? 32'h08 : 32'h00);
    end
    // All-ones corners first, loop bit kept off so fine gain shows
    for (int k = 0; k < 30; k++) begin
      i = k % 6;
      w = k < 6 ? 32'hFFFFFFFF : $random(seed);
      if (i == 1) w[7] = 1'b0;
      apb(1'b1, ofs[i], w, e);
      apb(1'b0, ofs[i], 32'h0, e);
      check(rd, {24'h0, w[7:0] & msk[i]});
      check({24'h0, obs(i)}, i == 5 ? 32'h0 : {24'h0, w[7:0] & msk[i] & ~{i == 1, 7'h0}});
    end
    apb(1'b1, HSTC_OFS_HCBT, 32'h08, e);
    apb(1'b1, 8'h14, 32'hFF, e);
    check({31'h0, e}, 32'h1);
    apb(1'b0, 8'h14, 32'h0, e);
    check({e, rd[30:0]}, 32'h80000000);
    prog_voltage_pin <= 1'b1;
    for (int j = 0; j < 7; j++) begin
      apb(1'b1, HSTC_OFS_DIAG, {24'h0, codes[j]}, e);
      repeat (6) @(posedge pclk);
      check({28'h0, diag_active, pin_route}, {28'h0, codes[j] != 8'h00, routes[j]});
      if (j != 0) check({29'h0, pin_u, pin_z, pin_b}, 32'h0);
    end
    prog_voltage_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    check({31'h0, diag_active}, 32'h0);
    apb(1'b1, HSTC_OFS_DIAG, 32'h0, e);
    apb(1'b1, HSTC_OFS_GAIN, 32'h45, e);
    apb(1'b1, HSTC_OFS_LOOP, 32'h80, e);
    repeat (300) @(posedge pclk);
    check({31'h0, second_gain - target + 6'h2 <= 6'h4}, 32'h1);
    apb(1'b1, HSTC_OFS_GAIN, 32'h7F, e);
    check({31'h0, second_gain - target + 6'h2 <= 6'h4}, 32'h1);
    target <= 6'h28;
    repeat (300) @(posedge pclk);
    check({31'h0, second_gain - target + 6'h2 <= 6'h4}, 32'h1);
    // Setpoint out of reach: loop pins at full gain and shows limit
    lim <= 1'b1;
    repeat (300) @(posedge pclk);
    apb(1'b0, HSTC_OFS_STAT, 32'h0, e);
    check(rd, 32'h0000023F);
    apb(1'b1, HSTC_OFS_GAIN, 32'hFF, e);
    check({30'h0, coarse_gain}, 32'h3);
    apb(1'b1, HSTC_OFS_LOOP, 32'h0, e);
    check({26'h0, second_gain}, 32'h3F);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
